/* File: rds_map.svh */
// Offsets, field positions, reset values and timing figures of the pixel front end.
// Included by the rds_front module only; holds definitions only.
`ifndef RDS_MAP_SVH
`define RDS_MAP_SVH
`define RDS_CLK_MHZ 200
`define RDS_STATIC_NS 1000
`define RDS_BIT_CYC 2
`define RDS_HDR_BITS 5'h10
`define RDS_CMD_BITS 5'h18
`define RDS_RW_BIT 15
`define RDS_SEL_HI 14
`define RDS_SEL_LO 13
`define RDS_ADDR_HI 7
`define RDS_ADDR_LO 0
`define RDS_SEL_CFG 2'h0
`define RDS_CFG_ADDR 8'h00
`define RDS_CFG_LUT_BIT 0
`define RDS_CFG_DITH_BIT 1
`define RDS_CFG_RST 8'h02
`define RDS_LANE_BITS 8
`define RDS_LANES 3
`define RDS_W_SEQ_HI 23
`define RDS_W_SEQ_LO 21
`define RDS_W_VS 20
`define RDS_W_HS 19
`define RDS_W_DE 18
`define RDS_SAT6 6'h3f
`endif

/* File: rds_pkg.sv */
// Types shared by the pixel front end modules.
// Assumes rds_map.svh supplies the numeric constants.
package rds_pkg;
  typedef struct packed {
    logic vs;
    logic hs;
    logic de;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } rds_pix_s;

  typedef enum logic [1:0] {
    RDS_SP_HDR = 2'h0,
    RDS_SP_WDATA = 2'h1,
    RDS_SP_RDATA = 2'h2,
    RDS_SP_DONE = 2'h3
  } rds_sp_e;

  typedef logic [23:0] rds_word_t;
endpackage : rds_pkg

/* File: rds_cc_table.sv */
// Three 256 x 8 colour correction memories, one per channel.
// No reset: contents survive sleep. Reads are asynchronous; the caller registers them.
`timescale 1ns/10ps
module rds_cc_table (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic [1:0] wr_ch_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [2:0][7:0] pix_addr_i,
  output logic [2:0][7:0] pix_data_o,
  input wire logic [1:0] cfg_ch_i,
  input wire logic [7:0] cfg_addr_i,
  output logic [7:0] cfg_data_o
);
  logic [2:0][7:0] cfg_rd;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_ch
      logic [7:0] mem [0:255];
      always_ff @(posedge clk_i) begin
        if (wr_i && (wr_ch_i == 2'(ch))) begin
          mem[wr_addr_i] <= wr_data_i;
        end
      end
      assign pix_data_o[ch] = mem[pix_addr_i[ch]];
      assign cfg_rd[ch] = mem[cfg_addr_i];
    end
  endgenerate

  assign cfg_data_o = (cfg_ch_i < 2'h3) ? cfg_rd[cfg_ch_i] : 8'h00;
endmodule : rds_cc_table

/* File: rds_front.sv */
// Pixel capture, colour correction, 24-to-18 dither and three-lane serializer.
// Assumes a free 200 MHz clk_i; pixel clock and all pins are asynchronous to it.
`timescale 1ns/10ps
`include "rds_map.svh"
module rds_front import rds_pkg::*; #(
  parameter int BIT_CYC = `RDS_BIT_CYC,
  parameter int STATIC_NS = `RDS_STATIC_NS
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pixel_clock_i,
  input wire logic [7:0] red_i,
  input wire logic [7:0] green_i,
  input wire logic [7:0] blue_i,
  input wire logic vertical_sync_i,
  input wire logic pixel_valid_i,
  input wire logic power_down_n_i,
  input wire logic test_select_i,
  input wire logic config_select_n_i,
  input wire logic config_clock_i,
  input wire logic config_data_or_hsync_i,
  output logic config_data_o,
  output logic config_data_oe_n_o,
  output logic [2:0] serial_data_lines_o,
  output logic link_clock_line_o
);
  localparam int STATIC_CYC = (STATIC_NS * `RDS_CLK_MHZ + 999) / 1000;
  localparam int SCW = $clog2(STATIC_CYC + 1);
  localparam int HALF = BIT_CYC / 2;

  generate
    if (BIT_CYC < 2 || BIT_CYC > 15 || STATIC_CYC < 1) begin : g_bad
      $error("rds_front: BIT_CYC must be 2..15 and STATIC_NS positive");
    end
  endgenerate

  // Two-stage synchronisers for everything arriving from pins
  rds_pix_s vin, vin_s1, vin_s2, px;
  logic [5:0] ctl_s1, ctl_s2;
  logic pclk_d, scl_d, px_vld;
  logic [SCW-1:0] st_cnt;
  assign vin = '{vs: vertical_sync_i, hs: 1'b0, de: pixel_valid_i,
                 r: red_i, g: green_i, b: blue_i};
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      vin_s1 <= '0;
      vin_s2 <= '0;
      ctl_s1 <= 6'h00;
      ctl_s2 <= 6'h00;
    end else begin
      vin_s1 <= vin;
      vin_s2 <= vin_s1;
      ctl_s1 <= {test_select_i, pixel_clock_i, power_down_n_i, config_select_n_i,
                 config_clock_i, config_data_or_hsync_i};
      ctl_s2 <= ctl_s1;
    end
  end
  logic pclk_s, pdn_s, cs_n_s, scl_s, sdh_s, sleep, pclk_rise, spi_ok;
  assign {pclk_s, pdn_s, cs_n_s, scl_s, sdh_s} = ctl_s2[4:0];
  assign sleep = ~pdn_s;
  assign pclk_rise = pclk_s & ~pclk_d;

  // Capture stage and pixel clock activity watch
  rds_pix_s next_px;
  logic next_px_vld;
  logic [SCW-1:0] next_st_cnt;
  always_comb begin
    next_px = px;
    next_px_vld = pclk_rise & ~sleep;
    if (pclk_rise) begin
      next_px = vin_s2;
      next_px.hs = cs_n_s & sdh_s;
    end
    if (pclk_s != pclk_d) begin
      next_st_cnt = '0;
    end else if (st_cnt != SCW'(STATIC_CYC)) begin
      next_st_cnt = st_cnt + SCW'(1);
    end else begin
      next_st_cnt = st_cnt;
    end
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      px <= '0;
      px_vld <= 1'b0;
      pclk_d <= 1'b0;
      st_cnt <= '0;
    end else begin
      px <= next_px;
      px_vld <= next_px_vld;
      pclk_d <= pclk_s;
      st_cnt <= next_st_cnt;
    end
  end
  assign spi_ok = ~cs_n_s & pdn_s & (st_cnt == SCW'(STATIC_CYC));

  // Configuration port
  rds_sp_e sp_state, next_sp_state;
  logic [4:0] sp_cnt, next_sp_cnt;
  logic [15:0] sp_sh, next_sp_sh, sp_hdr, next_sp_hdr, hdr_new;
  logic [7:0] cfg, next_cfg, rd_sh, next_rd_sh, tbl_rd, rd_val;
  logic next_sda, next_sda_oe_n, tbl_wr, scl_rise, scl_fall;
  logic [1:0] sel_new;
  assign hdr_new = {sp_sh[14:0], sdh_s};
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign sel_new = hdr_new[`RDS_SEL_HI:`RDS_SEL_LO];
  assign rd_val = (sel_new == `RDS_SEL_CFG) ? cfg : tbl_rd;
  always_comb begin
    next_sp_state = sp_state;
    next_sp_cnt = sp_cnt;
    next_sp_sh = sp_sh;
    next_sp_hdr = sp_hdr;
    next_cfg = cfg;
    next_rd_sh = rd_sh;
    next_sda = config_data_o;
    next_sda_oe_n = config_data_oe_n_o;
    tbl_wr = 1'b0;
    if (sleep) begin
      next_cfg = `RDS_CFG_RST;
    end
    if (!spi_ok) begin
      next_sp_state = RDS_SP_HDR;
      next_sp_cnt = 5'h00;
      next_sda = 1'b0;
      next_sda_oe_n = 1'b1;
    end else begin
      case (sp_state)
        RDS_SP_HDR: begin
          if (scl_rise) begin
            next_sp_sh = hdr_new;
            next_sp_cnt = sp_cnt + 5'h01;
            if (sp_cnt == `RDS_HDR_BITS - 5'h01) begin
              next_sp_hdr = hdr_new;
              if (hdr_new[`RDS_RW_BIT]) begin
                next_rd_sh = rd_val;
                next_sda = rd_val[7];
                next_sda_oe_n = 1'b0;
                next_sp_state = RDS_SP_RDATA;
              end else begin
                next_sp_state = RDS_SP_WDATA;
              end
            end
          end
        end
        RDS_SP_WDATA: begin
          if (scl_rise) begin
            next_sp_sh = hdr_new;
            next_sp_cnt = sp_cnt + 5'h01;
            if (sp_cnt == `RDS_CMD_BITS - 5'h01) begin
              next_sp_state = RDS_SP_DONE;
              if (sp_hdr[`RDS_SEL_HI:`RDS_SEL_LO] != `RDS_SEL_CFG) begin
                tbl_wr = 1'b1;
              end else if (sp_hdr[`RDS_ADDR_HI:`RDS_ADDR_LO] == `RDS_CFG_ADDR) begin
                next_cfg = hdr_new[7:0];
              end
            end
          end
        end
        RDS_SP_RDATA: begin
          if (scl_fall) begin
            next_rd_sh = {rd_sh[6:0], 1'b0};
            next_sda = rd_sh[6];
          end
          if (scl_rise) begin
            next_sp_cnt = sp_cnt + 5'h01;
            if (sp_cnt == `RDS_CMD_BITS - 5'h01) begin
              next_sp_state = RDS_SP_DONE;
              next_sda_oe_n = 1'b1;
            end
          end
        end
        default: begin
          next_sda_oe_n = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sp_state <= RDS_SP_HDR;
      sp_cnt <= 5'h00;
      sp_sh <= 16'h0000;
      sp_hdr <= 16'h0000;
      cfg <= `RDS_CFG_RST;
      rd_sh <= 8'h00;
      scl_d <= 1'b0;
      config_data_o <= 1'b0;
      config_data_oe_n_o <= 1'b1;
    end else begin
      sp_state <= next_sp_state;
      sp_cnt <= next_sp_cnt;
      sp_sh <= next_sp_sh;
      sp_hdr <= next_sp_hdr;
      cfg <= next_cfg;
      rd_sh <= next_rd_sh;
      scl_d <= scl_s;
      config_data_o <= next_sda;
      config_data_oe_n_o <= next_sda_oe_n;
    end
  end

  // Table lookup stage; table write channel is select minus one
  logic [2:0][7:0] lut_out;
  rds_cc_table u_table (
    .clk_i(clk_i),
    .wr_i(tbl_wr),
    .wr_ch_i(sp_hdr[`RDS_SEL_HI:`RDS_SEL_LO] - 2'h1),
    .wr_addr_i(sp_hdr[`RDS_ADDR_HI:`RDS_ADDR_LO]),
    .wr_data_i(hdr_new[7:0]),
    // Element 0 is red so each colour meets the table its select code writes
    .pix_addr_i({px.b, px.g, px.r}),
    .pix_data_o(lut_out),
    .cfg_ch_i(sel_new - 2'h1),
    .cfg_addr_i(hdr_new[`RDS_ADDR_HI:`RDS_ADDR_LO]),
    .cfg_data_o(tbl_rd)
  );

  // Ordered 2x2 dither; threshold rotates each frame so error averages out
  function automatic logic [5:0] rds_dith(input logic [7:0] v, input logic [1:0] t,
                                          input logic en);
    logic [8:0] s;
    s = {1'b0, v} + {7'h00, (en ? t : 2'h0)};
    return s[8] ? `RDS_SAT6 : s[7:2];
  endfunction : rds_dith

  rds_pix_s lp, next_lp;
  logic lv, next_lv, wv, next_wv, prev_vs, next_prev_vs, prev_de, next_prev_de;
  logic xpar, next_xpar, ypar, next_ypar, vs_rise;
  logic [1:0] frame, next_frame, thr;
  logic [2:0] seq, next_seq, wseq;
  rds_word_t word, next_word;
  assign vs_rise = lp.vs & ~prev_vs;
  assign thr = {ypar, xpar} ^ frame;
  always_comb begin
    next_lv = px_vld & ~sleep;
    next_lp = px;
    if (cfg[`RDS_CFG_LUT_BIT]) begin
      {next_lp.b, next_lp.g, next_lp.r} = lut_out;
    end
    next_wv = lv & ~sleep;
    next_word = word;
    next_prev_vs = prev_vs;
    next_prev_de = prev_de;
    next_xpar = xpar;
    next_ypar = ypar;
    next_frame = frame;
    next_seq = seq;
    wseq = vs_rise ? 3'h0 : seq;
    if (lv) begin
      next_word = {wseq, lp.vs, lp.hs, lp.de,
                   rds_dith(lp.r, thr, cfg[`RDS_CFG_DITH_BIT]),
                   rds_dith(lp.g, thr, cfg[`RDS_CFG_DITH_BIT]),
                   rds_dith(lp.b, thr, cfg[`RDS_CFG_DITH_BIT])};
      next_seq = wseq + 3'h1;
      next_prev_vs = lp.vs;
      next_prev_de = lp.de;
      next_xpar = lp.de & ~xpar;
      next_ypar = (prev_de & ~lp.de) ? ~ypar : ypar;
      if (vs_rise) begin
        next_frame = frame + 2'h1;
        next_ypar = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lp <= '0;
      lv <= 1'b0;
      wv <= 1'b0;
      word <= '0;
      prev_vs <= 1'b0;
      prev_de <= 1'b0;
      xpar <= 1'b0;
      ypar <= 1'b0;
      frame <= 2'h0;
      seq <= 3'h0;
    end else begin
      lp <= next_lp;
      lv <= next_lv;
      wv <= next_wv;
      word <= next_word;
      prev_vs <= next_prev_vs;
      prev_de <= next_prev_de;
      xpar <= next_xpar;
      ypar <= next_ypar;
      frame <= next_frame;
      seq <= next_seq;
    end
  end

  // Serializer: eight bits per lane, one spare word held while busy
  rds_word_t ser_sh, next_ser_sh, pend, next_pend;
  logic pend_v, next_pend_v, busy, next_busy, ser_end, ser_load;
  logic [3:0] ph, next_ph;
  logic [2:0] bitc, next_bitc;
  logic [2:0] next_md;
  assign ser_end = busy && (ph == 4'(BIT_CYC - 1)) && (bitc == 3'h7);
  assign ser_load = (!busy || ser_end) && (pend_v || wv);
  always_comb begin
    next_ser_sh = ser_sh;
    next_pend = pend;
    next_pend_v = pend_v;
    next_busy = busy;
    next_ph = ph;
    next_bitc = bitc;
    if (busy) begin
      next_ph = (ph == 4'(BIT_CYC - 1)) ? 4'h0 : ph + 4'h1;
      if (ph == 4'(BIT_CYC - 1)) begin
        next_bitc = bitc + 3'h1;
        for (int i = 0; i < `RDS_LANES; i++) begin
          next_ser_sh[i*`RDS_LANE_BITS +: `RDS_LANE_BITS] =
            {ser_sh[i*`RDS_LANE_BITS +: `RDS_LANE_BITS-1], 1'b0};
        end
        if (bitc == 3'h7) begin
          next_busy = 1'b0;
        end
      end
    end
    if (ser_load) begin
      next_ser_sh = pend_v ? pend : word;
      next_busy = 1'b1;
      next_ph = 4'h0;
      next_bitc = 3'h0;
      next_pend_v = pend_v & wv;
      if (wv) begin
        next_pend = word;
      end
    end else if (wv) begin
      next_pend = word;
      next_pend_v = 1'b1;
    end
    if (sleep) begin
      next_busy = 1'b0;
      next_pend_v = 1'b0;
    end
    for (int i = 0; i < `RDS_LANES; i++) begin
      next_md[i] = next_busy & next_ser_sh[i*`RDS_LANE_BITS + `RDS_LANE_BITS - 1];
    end
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ser_sh <= '0;
      pend <= '0;
      pend_v <= 1'b0;
      busy <= 1'b0;
      ph <= 4'h0;
      bitc <= 3'h0;
      serial_data_lines_o <= 3'h0;
      link_clock_line_o <= 1'b0;
    end else begin
      ser_sh <= next_ser_sh;
      pend <= next_pend;
      pend_v <= next_pend_v;
      busy <= next_busy;
      ph <= next_ph;
      bitc <= next_bitc;
      serial_data_lines_o <= next_md;
      link_clock_line_o <= next_busy && (next_ph >= 4'(HALF));
    end
  end

  // Checks
  sequence s_load;
    ser_load && !sleep;
  endsequence
  sequence s_first_bit;
    !link_clock_line_o ##1 link_clock_line_o;
  endsequence
  a_capture_on_edge: assert property (@(posedge clk_i) disable iff (reset_i)
    pclk_rise && !sleep |=> px_vld && px.r == $past(vin_s2.r))
    else $error("pixel not captured on pixel clock rise");
  a_sleep_cfg_reset: assert property (@(posedge clk_i) disable iff (reset_i)
    sleep |=> cfg == `RDS_CFG_RST)
    else $error("config not reset in sleep");
  a_port_ignored: assert property (@(posedge clk_i) disable iff (reset_i)
    !spi_ok |=> sp_cnt == 5'h00 && sp_state == RDS_SP_HDR)
    else $error("config port active while not allowed");
  a_sda_input_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    cs_n_s || sp_state != RDS_SP_RDATA |=> config_data_oe_n_o || sp_state == RDS_SP_RDATA)
    else $error("shared pin driven outside a read");
  a_hsync_route: assert property (@(posedge clk_i) disable iff (reset_i)
    pclk_rise |=> px.hs == ($past(cs_n_s) & $past(sdh_s)))
    else $error("horizontal sync routing wrong");
  a_vs_unchanged: assert property (@(posedge clk_i) disable iff (reset_i)
    wv |-> word[`RDS_W_VS] == $past(px.vs, 2) && $past(px_vld, 2))
    else $error("vertical sync altered across pipeline");
  a_dither_bypass: assert property (@(posedge clk_i) disable iff (reset_i)
    lv && !cfg[`RDS_CFG_DITH_BIT] |=> word[17:12] == $past(lp.r[7:2]))
    else $error("truncation path wrong");
  a_table_bypass: assert property (@(posedge clk_i) disable iff (reset_i)
    px_vld && !cfg[`RDS_CFG_LUT_BIT] |=> lp.g == $past(px.g))
    else $error("table bypass altered pixel");
  a_seq_resync: assert property (@(posedge clk_i) disable iff (reset_i)
    lv && vs_rise |=> word[`RDS_W_SEQ_HI:`RDS_W_SEQ_LO] == 3'h0)
    else $error("frame sequence not restarted");
  a_link_clock_run: assert property (@(posedge clk_i) disable iff (reset_i)
    s_load |=> s_first_bit)
    else $error("link clock not started after load");
endmodule : rds_front

/* File: rds_link_sink.sv */
// Display-side model: rebuilds 24-bit words from the three lanes.
// Assumes lanes settle while the link clock is low and sync to clk_i.
`timescale 1ns/10ps
module rds_link_sink import rds_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [2:0] lanes_i,
  input wire logic lclk_i,
  output rds_word_t word_o,
  output logic word_vld_o
);
  logic lclk_q;
  logic [2:0] gap;
  logic [2:0] cnt;
  logic [2:0][7:0] sh;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lclk_q <= 1'b0;
      gap <= 3'h0;
      cnt <= 3'h0;
      sh <= '0;
      word_vld_o <= 1'b0;
      word_o <= '0;
    end else begin
      lclk_q <= lclk_i;
      word_vld_o <= 1'b0;
      gap <= lclk_i ? 3'h0 : (gap == 3'h7 ? gap : gap + 3'h1);
      // Idle link restarts word framing, so a broken word cannot shift later ones
      if (gap > 3'h3 && !lclk_i) cnt <= 3'h0;
      if (lclk_i && !lclk_q) begin
        for (int i = 0; i < 3; i++) sh[i] <= {sh[i][6:0], lanes_i[i]};
        cnt <= cnt + 3'h1;
        if (cnt == 3'h7) begin
          word_vld_o <= 1'b1;
          word_o <= {sh[2][6:0], lanes_i[2], sh[1][6:0], lanes_i[1], sh[0][6:0], lanes_i[0]};
        end
      end
    end
  end
endmodule : rds_link_sink

/* File: rds_front_bench.sv */
// Self-checking bench for rds_front: host pins, config port tasks, link sink.
// Assumes short STATIC_NS so the config port opens soon after pixel clock stops.
`timescale 1ns/10ps
module rds_front_bench import rds_pkg::*;;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic pclk = 1'b0;
  logic pclk_run = 1'b0;
  logic [7:0] red = 8'h00;
  logic [7:0] green = 8'h00;
  logic [7:0] blue = 8'h00;
  logic vs = 1'b0;
  logic de = 1'b0;
  logic pdn = 1'b1;
  logic tsel = 1'b0;
  logic csn = 1'b1;
  logic sck = 1'b0;
  logic sdo = 1'b0;
  logic sda;
  logic dout;
  logic oe_n;
  logic [2:0] lanes;
  logic lclk;
  logic wvld;
  rds_word_t word;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [7:0] colour_correction_table [3][256];
  logic m_lut = 1'b0;
  logic m_dith = 1'b1;
  logic watch = 1'b0;
  logic vs_q = 1'b0;
  logic [2:0] seq = 3'h0;
  rds_word_t exq[$];

  // Shared pin level comes from whichever side has it enabled
  assign sda = (oe_n === 1'b0) ? dout : sdo;

  rds_front #(.BIT_CYC(2), .STATIC_NS(100)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .pixel_clock_i(pclk),
    .red_i(red), .green_i(green), .blue_i(blue),
    .vertical_sync_i(vs), .pixel_valid_i(de), .power_down_n_i(pdn),
    .test_select_i(tsel), .config_select_n_i(csn), .config_clock_i(sck),
    .config_data_or_hsync_i(sda), .config_data_o(dout), .config_data_oe_n_o(oe_n),
    .serial_data_lines_o(lanes), .link_clock_line_o(lclk));

  rds_link_sink sink (.clk_i(clk_i), .reset_i(reset_i), .lanes_i(lanes), .lclk_i(lclk),
    .word_o(word), .word_vld_o(wvld));

  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    #1.3;
    forever begin
      #40;
      if (pclk_run) pclk = ~pclk;
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  initial begin
    #200000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] pv(int ch, int k, logic [7:0] b);
    return (8'hff - 8'(k) * 8'h11) ^ b ^ 8'(ch * 8'h47);
  endfunction : pv

  function automatic logic [5:0] cv(int ch, logic [7:0] v);
    logic [7:0] c;
    c = m_lut ? colour_correction_table[ch][v] : v;
    return c[7:2];
  endfunction : cv

  function automatic logic ok6(logic [5:0] g, logic [5:0] t);
    return (g === t) || (m_dith && t != 6'h3f && g === t + 6'h01);
  endfunction : ok6

  always @(posedge pclk) begin
    seq = (vs && !vs_q) ? 3'h0 : seq + 3'h1;
    vs_q = vs;
    if (watch) exq.push_back({seq, vs, sdo, de, cv(0, red), cv(1, green), cv(2, blue)});
  end

  // Mid-cycle look so the one-cycle word strobe is settled
  always @(negedge clk_i) begin
    rds_word_t e;
    if (watch && wvld === 1'b1) begin
      cmp_count++;
      e = (exq.size() > 0) ? exq.pop_front() : '1;
      if (word[23:18] !== e[23:18] || !ok6(word[17:12], e[17:12]) ||
          !ok6(word[11:6], e[11:6]) || !ok6(word[5:0], e[5:0])) begin
        n_mismatch++;
        $display("mismatch at %0t: word %h exp %h", $time, word, e);
      end
    end
  end

  task automatic spi(input logic [23:0] cmd, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clk_i);
    csn = 1'b0;
    for (int i = 0; i < 24; i++) begin
      sdo = cmd[23 - i];
      repeat (8) @(negedge clk_i);
      sck = 1'b1;
      repeat (6) @(negedge clk_i);
      chk(oe_n, !(cmd[23] && i > 14 && i < 23), "data enable");
      if (cmd[23] && i > 14 && i < 23) rd[22 - i] = sda;
      repeat (2) @(negedge clk_i);
      sck = 1'b0;
    end
    repeat (8) @(negedge clk_i);
    csn = 1'b1;
    sdo = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask : spi

  task automatic wr(input logic [1:0] t, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rd;
    spi({1'b0, t, 5'h00, a, d}, rd);
    if (t == 2'h0 && a == 8'h00) {m_dith, m_lut} = d[1:0];
    else if (t != 2'h0) colour_correction_table[t - 2'h1][a] = d;
  endtask : wr

  task automatic rdchk(input logic [1:0] t, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] rd;
    spi({1'b1, t, 5'h00, a, 8'h00}, rd);
    chk(rd, e, "read back");
  endtask : rdchk

  task automatic stream(input int n, input logic [7:0] b);
    watch = 1'b1;
    for (int k = 0; k < n; k++) begin
      if (k > 0) @(negedge pclk);
      @(negedge clk_i);
      red = pv(0, k, b);
      green = pv(1, k, b);
      blue = pv(2, k, b);
      vs = (k == 0);
      sdo = k[0];
      de = (k > 1);
      if (k == 0) pclk_run = 1'b1;
    end
    @(negedge pclk);
    pclk_run = 1'b0;
    @(negedge clk_i);
    vs = 1'b0;
    repeat (40) @(negedge clk_i);
    chk(exq.size(), 0, "words not delivered");
    watch = 1'b0;
    exq.delete();
  endtask : stream

  initial begin
    logic [7:0] rd;
    repeat (20) @(negedge clk_i);
    chk({lanes, lclk, dout, oe_n}, 6'h01, "reset outputs");
    reset_i = 1'b0;
    repeat (40) @(negedge clk_i);
    rdchk(2'h0, 8'h00, 8'h02);
    wr(2'h0, 8'h00, 8'h00);
    stream(12, 8'h00);
    stream(6, 8'h3c);
    for (int k = 0; k < 6; k++)
      for (int t = 1; t < 4; t++) wr(2'(t), pv(t - 1, k, 8'h5a), pv(t, k, 8'hc3));
    for (int t = 1; t < 4; t++) rdchk(2'(t), pv(t - 1, 3, 8'h5a), pv(t, 3, 8'hc3));
    wr(2'h0, 8'h00, 8'h01);
    stream(6, 8'h5a);
    // Pixel clock running: port must stay shut
    pclk_run = 1'b1;
    spi({1'b0, 2'h0, 5'h00, 8'h00, 8'h00}, rd);
    @(negedge pclk);
    pclk_run = 1'b0;
    repeat (40) @(negedge clk_i);
    rdchk(2'h0, 8'h00, 8'h01);
    pdn = 1'b0;
    pclk_run = 1'b1;
    repeat (40) @(negedge clk_i);
    chk({lanes, lclk}, 4'h0, "link idle in sleep");
    @(negedge pclk);
    pclk_run = 1'b0;
    repeat (40) @(negedge clk_i);
    spi({1'b0, 2'h1, 5'h00, pv(0, 0, 8'h5a), 8'h00}, rd);
    pdn = 1'b1;
    repeat (10) @(negedge clk_i);
    {m_dith, m_lut} = 2'h2;
    rdchk(2'h0, 8'h00, 8'h02);
    rdchk(2'h1, pv(0, 0, 8'h5a), colour_correction_table[0][pv(0, 0, 8'h5a)]);
    stream(8, 8'h00);
    conclude();
  end
endmodule : rds_front_bench
